// [verilog/srrd_decode.sv]
// decoder and clock-count sequencer for returns, shifts, flag load and borrow subtract
`timescale 1ns/100ps
`include "srrd_regs.svh"
module srrd_decode (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic             start,
  input  wire logic [7:0]       opcode,
  input  wire logic [7:0]       modrm,
  input  wire logic             prot_mode,
  input  wire logic             priv_change,
  input  wire logic             cache_miss,
  output logic                  busy,
  output logic                  done,
  output logic                  illegal,
  output srrd_pkg::srrd_op_e    op,
  output logic                  rotate_left_op,
  output logic                  rotate_right_op,
  output logic                  arith_shift_left_op,
  output logic                  arith_shift_right_op,
  output logic                  subroutine_return_op,
  output logic                  flags_from_acc_high_op,
  output logic                  subtract_with_borrow_op,
  output logic                  use_count_reg_low,
  output logic                  add_imm_stack_pointer,
  output logic                  full_width,
  output logic                  mem_operand,
  output logic [5:0]            flag_mask,
  output logic [6:0]            clocks
);

  // ****************************************
  // helper functions
  // ****************************************
  function automatic logic [6:0] srrd_pick(input logic is_mem, input logic miss,
                                           input logic [6:0] reg_c, input logic [6:0] hit_c,
                                           input logic [6:0] miss_c);
    srrd_pick = !is_mem ? reg_c : (miss ? miss_c : hit_c);
  endfunction : srrd_pick

  // ****************************************
  // combinational decode
  // ****************************************
  srrd_pkg::srrd_op_e dec_op;
  logic [6:0]         dec_clk;
  logic [5:0]         dec_flags;
  logic               dec_ok;
  logic               dec_cnt;
  logic               dec_imm;
  logic               dec_mem;
  logic [2:0]         sel;

  always_comb begin
    sel       = modrm[5:3];
    dec_op    = srrd_pkg::SRRD_OP_NONE;
    dec_clk   = 7'h00;
    dec_flags = 6'h00;
    dec_ok    = 1'b0;
    dec_cnt   = 1'b0;
    dec_imm   = 1'b0;
    dec_mem   = (modrm[7:6] != `SRRD_MOD_REG);
    if (opcode == `SRRD_OP_RET_NEAR || opcode == `SRRD_OP_RET_NEAR_IMM) begin
      dec_op  = srrd_pkg::SRRD_OP_RET;
      dec_ok  = 1'b1;
      dec_mem = 1'b0;
      dec_imm = (opcode == `SRRD_OP_RET_NEAR_IMM);
      dec_clk = `SRRD_CLK_RET_NEAR;
    end else if (opcode == `SRRD_OP_RET_FAR_IMM || opcode == `SRRD_OP_RET_FAR) begin
      dec_op  = srrd_pkg::SRRD_OP_RET;
      dec_ok  = 1'b1;
      dec_mem = 1'b0;
      dec_imm = (opcode == `SRRD_OP_RET_FAR_IMM);
      if (!prot_mode) begin
        dec_clk = `SRRD_CLK_RET_FAR_R;
      end else if (priv_change) begin
        dec_clk = cache_miss ? `SRRD_CLK_RET_PRIV_M : `SRRD_CLK_RET_PRIV_H;
      end else begin
        dec_clk = cache_miss ? `SRRD_CLK_RET_FAR_PM : `SRRD_CLK_RET_FAR_P;
      end
    end else if (opcode[7:1] == `SRRD_OP_SHIFT_ONE || opcode[7:1] == `SRRD_OP_SHIFT_IMM ||
                 opcode[7:1] == `SRRD_OP_SHIFT_CNT) begin
      dec_cnt = (opcode[7:1] == `SRRD_OP_SHIFT_CNT);
      dec_ok  = 1'b1;
      dec_flags = `SRRD_FLAGS_SHIFT;
      case (sel)
        `SRRD_SEL_ROL: dec_op = srrd_pkg::SRRD_OP_ROL;
        `SRRD_SEL_ROR: dec_op = srrd_pkg::SRRD_OP_ROR;
        `SRRD_SEL_SAL: dec_op = srrd_pkg::SRRD_OP_SAL;
        `SRRD_SEL_SAR: dec_op = srrd_pkg::SRRD_OP_SAR;
        default:       dec_ok = 1'b0;
      endcase
      if (dec_op == srrd_pkg::SRRD_OP_SAL || dec_op == srrd_pkg::SRRD_OP_SAR) begin
        dec_flags = 6'h3b;
      end
      if (dec_cnt) begin
        dec_clk = srrd_pick(dec_mem, cache_miss, `SRRD_CLK_SHC_REG, `SRRD_CLK_SHC_HIT,
                            `SRRD_CLK_SHC_MISS);
      end else begin
        dec_clk = srrd_pick(dec_mem, cache_miss, `SRRD_CLK_SH1_REG, `SRRD_CLK_SH1_HIT,
                            `SRRD_CLK_SH1_MISS);
      end
    end else if (opcode == `SRRD_OP_FLAGS_AH) begin
      dec_op    = srrd_pkg::SRRD_OP_FLAGS;
      dec_ok    = 1'b1;
      dec_mem   = 1'b0;
      dec_flags = `SRRD_FLAGS_FLAGS_FROM_ACC_HIGH_OP;
      dec_clk   = `SRRD_CLK_FLAGS_AH;
    end else if (opcode[7:2] == `SRRD_OP_SBB_RR_HI && !dec_mem) begin
      dec_op    = srrd_pkg::SRRD_OP_SBB;
      dec_ok    = 1'b1;
      dec_flags = `SRRD_FLAGS_ARITH;
      dec_clk   = `SRRD_CLK_SBB_REG;
    end else if (opcode[7:1] == `SRRD_OP_SBB_RM || opcode[7:1] == `SRRD_OP_SBB_MR) begin
      dec_op    = srrd_pkg::SRRD_OP_SBB;
      dec_ok    = 1'b1;
      dec_flags = `SRRD_FLAGS_ARITH;
      dec_clk   = cache_miss ? `SRRD_CLK_SBB_MISS : `SRRD_CLK_SBB_HIT;
    end else if (opcode[7:2] == `SRRD_OP_IMM_GRP && sel == `SRRD_SEL_SBB) begin
      dec_op    = srrd_pkg::SRRD_OP_SBB;
      dec_ok    = 1'b1;
      dec_imm   = 1'b1;
      dec_flags = `SRRD_FLAGS_ARITH;
      dec_clk   = srrd_pick(dec_mem, cache_miss, `SRRD_CLK_SBB_REG, `SRRD_CLK_SBB_HIT,
                            `SRRD_CLK_SBB_MISS);
    end else if (opcode[7:1] == `SRRD_OP_SBB_ACC) begin
      dec_op    = srrd_pkg::SRRD_OP_SBB;
      dec_ok    = 1'b1;
      dec_mem   = 1'b0;
      dec_imm   = 1'b1;
      dec_flags = `SRRD_FLAGS_ARITH;
      dec_clk   = `SRRD_CLK_SBB_REG;
    end
    if (!dec_ok) begin
      dec_op    = srrd_pkg::SRRD_OP_NONE;
      dec_clk   = 7'h00;
      dec_flags = 6'h00;
      dec_mem   = 1'b0;
    end
  end

  // ****************************************
  // sequencer: holds decode, counts clocks
  // ****************************************
  srrd_pkg::srrd_state_e state_r, state_nxt;
  srrd_pkg::srrd_op_e    op_r, op_nxt;
  logic [6:0]            clk_r, clk_nxt;
  logic [6:0]            cnt_r, cnt_nxt;
  logic [5:0]            flg_r, flg_nxt;
  logic                  ill_r, ill_nxt;
  logic                  cntreg_r, cntreg_nxt;
  logic                  imm_r, imm_nxt;
  logic                  wide_r, wide_nxt;
  logic                  mem_r, mem_nxt;

  always_comb begin
    state_nxt  = state_r;
    op_nxt     = op_r;
    clk_nxt    = clk_r;
    cnt_nxt    = cnt_r;
    flg_nxt    = flg_r;
    ill_nxt    = 1'b0;
    cntreg_nxt = cntreg_r;
    imm_nxt    = imm_r;
    wide_nxt   = wide_r;
    mem_nxt    = mem_r;
    case (state_r)
      srrd_pkg::SRRD_IDLE, srrd_pkg::SRRD_DONE: begin
        state_nxt = srrd_pkg::SRRD_IDLE;
        if (start) begin
          if (dec_ok) begin
            state_nxt  = (dec_clk == 7'h01) ? srrd_pkg::SRRD_DONE : srrd_pkg::SRRD_BUSY;
            op_nxt     = dec_op;
            clk_nxt    = dec_clk;
            cnt_nxt    = dec_clk - 7'h01;
            flg_nxt    = dec_flags;
            cntreg_nxt = dec_cnt;
            imm_nxt    = dec_imm;
            wide_nxt   = opcode[0];
            mem_nxt    = dec_mem;
          end else begin
            ill_nxt = 1'b1;
          end
        end
      end
      srrd_pkg::SRRD_BUSY: begin
        cnt_nxt = cnt_r - 7'h01;
        if (cnt_r == 7'h01) begin
          state_nxt = srrd_pkg::SRRD_DONE;
        end
      end
      default: state_nxt = srrd_pkg::SRRD_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_r  <= srrd_pkg::SRRD_IDLE;
      op_r     <= srrd_pkg::SRRD_OP_NONE;
      clk_r    <= 7'h00;
      cnt_r    <= 7'h00;
      flg_r    <= 6'h00;
      ill_r    <= 1'b0;
      cntreg_r <= 1'b0;
      imm_r    <= 1'b0;
      wide_r   <= 1'b0;
      mem_r    <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      op_r     <= op_nxt;
      clk_r    <= clk_nxt;
      cnt_r    <= cnt_nxt;
      flg_r    <= flg_nxt;
      ill_r    <= ill_nxt;
      cntreg_r <= cntreg_nxt;
      imm_r    <= imm_nxt;
      wide_r   <= wide_nxt;
      mem_r    <= mem_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // start is ignored while busy; the issuing stage waits on done
  assign busy                    = (state_r == srrd_pkg::SRRD_BUSY);
  assign done                    = (state_r == srrd_pkg::SRRD_DONE);
  assign illegal                 = ill_r;
  assign op                      = op_r;
  assign rotate_left_op          = (op_r == srrd_pkg::SRRD_OP_ROL);
  assign rotate_right_op         = (op_r == srrd_pkg::SRRD_OP_ROR);
  assign arith_shift_left_op     = (op_r == srrd_pkg::SRRD_OP_SAL);
  assign arith_shift_right_op    = (op_r == srrd_pkg::SRRD_OP_SAR);
  assign subroutine_return_op    = (op_r == srrd_pkg::SRRD_OP_RET);
  assign flags_from_acc_high_op  = (op_r == srrd_pkg::SRRD_OP_FLAGS);
  assign subtract_with_borrow_op = (op_r == srrd_pkg::SRRD_OP_SBB);
  assign use_count_reg_low       = cntreg_r;
  assign add_imm_stack_pointer   = imm_r && (op_r == srrd_pkg::SRRD_OP_RET);
  assign full_width              = wide_r;
  assign mem_operand             = mem_r;
  assign flag_mask               = flg_r;
  assign clocks                  = clk_r;

  // ****************************************
  // checks
  // ****************************************
  // elapsed clocks from acceptance to done must equal the charged count
  logic [6:0] el_r;
  always_ff @(posedge mclk) begin
    if (reset || !busy) begin
      el_r <= 7'h01;
    end else begin
      el_r <= el_r + 7'h01;
    end
  end

  a_done_count_match: assert property (@(posedge mclk) disable iff (reset)
    $rose(done) && $past(busy) |-> clocks == el_r)
    else $error("done not at charged clock count");
  a_near_ret_ten: assert property (@(posedge mclk) disable iff (reset)
    (state_r != srrd_pkg::SRRD_BUSY) && !done && start && opcode == 8'hc3 |=> ##9 done)
    else $error("near return not 10 clocks");
  a_priv_ret_miss: assert property (@(posedge mclk) disable iff (reset)
    !busy && start && opcode[7:1] == 7'h65 && prot_mode && priv_change && cache_miss
    |=> clocks == 7'h40)
    else $error("privilege return miss count wrong");
  a_far_ret_real: assert property (@(posedge mclk) disable iff (reset)
    !busy && start && opcode == 8'hca && !prot_mode |=> clocks == 7'h0d)
    else $error("real far return count wrong");
  a_rol_select: assert property (@(posedge mclk) disable iff (reset)
    !busy && start && opcode[7:1] == 7'h68 && modrm[5:3] == 3'h0 |=> rotate_left_op)
    else $error("rotate left not selected");
  a_sar_select: assert property (@(posedge mclk) disable iff (reset)
    !busy && start && opcode[7:1] == 7'h60 && modrm[5:3] == 3'h7 |=> arith_shift_right_op)
    else $error("shift right not selected");
  a_shift_cnt_miss: assert property (@(posedge mclk) disable iff (reset)
    !busy && start && opcode[7:1] == 7'h69 && modrm[5:3] == 3'h1 && modrm[7:6] != 2'h3
    && cache_miss |=> clocks == 7'h07 && use_count_reg_low)
    else $error("count register shift miss count wrong");
  a_sbb_one_clock: assert property (@(posedge mclk) disable iff (reset)
    !busy && start && opcode[7:2] == 6'h06 && modrm[7:6] == 2'h3 |=> done && clocks == 7'h01)
    else $error("register borrow subtract not one clock");
  a_sbb_flags: assert property (@(posedge mclk) disable iff (reset)
    subtract_with_borrow_op |-> flag_mask == 6'h3f)
    else $error("borrow subtract flag mask incomplete");
  a_flags_ah: assert property (@(posedge mclk) disable iff (reset)
    !busy && start && opcode == 8'h9e |=> busy ##1 done)
    else $error("flag load not 2 clocks");
endmodule : srrd_decode

// [verilog/srrd_regs.svh]
// constants for the shift, rotate, return and borrow-subtract decode timing block
`ifndef SRRD_REGS_SVH
`define SRRD_REGS_SVH
`define SRRD_OP_RET_NEAR     8'hc3
`define SRRD_OP_RET_NEAR_IMM 8'hc2
`define SRRD_OP_RET_FAR_IMM  8'hca
`define SRRD_OP_RET_FAR      8'hcb
`define SRRD_OP_FLAGS_AH     8'h9e
`define SRRD_OP_SHIFT_IMM    7'h60
`define SRRD_OP_SHIFT_ONE    7'h68
`define SRRD_OP_SHIFT_CNT    7'h69
`define SRRD_OP_SBB_RR_HI    6'h06
`define SRRD_OP_SBB_RM       7'h0c
`define SRRD_OP_SBB_MR       7'h0d
`define SRRD_OP_SBB_ACC      7'h0e
`define SRRD_OP_IMM_GRP      6'h20
`define SRRD_SEL_ROL         3'h0
`define SRRD_SEL_ROR         3'h1
`define SRRD_SEL_SAL         3'h4
`define SRRD_SEL_SAR         3'h7
`define SRRD_SEL_SBB         3'h3
`define SRRD_MOD_REG         2'h3
`define SRRD_CLK_RET_NEAR    7'h0a
`define SRRD_CLK_RET_FAR_R   7'h0d
`define SRRD_CLK_RET_FAR_P   7'h1a
`define SRRD_CLK_RET_FAR_PM  7'h1b
`define SRRD_CLK_RET_PRIV_H  7'h3d
`define SRRD_CLK_RET_PRIV_M  7'h40
`define SRRD_CLK_SH1_REG     7'h02
`define SRRD_CLK_SH1_HIT     7'h04
`define SRRD_CLK_SH1_MISS    7'h06
`define SRRD_CLK_SHC_REG     7'h03
`define SRRD_CLK_SHC_HIT     7'h05
`define SRRD_CLK_SHC_MISS    7'h07
`define SRRD_CLK_FLAGS_AH    7'h02
`define SRRD_CLK_SBB_REG     7'h01
`define SRRD_CLK_SBB_HIT     7'h03
`define SRRD_CLK_SBB_MISS    7'h05
`define SRRD_FLAGS_FLAGS_FROM_ACC_HIGH_OP      6'h1f
`define SRRD_FLAGS_ARITH     6'h3f
`define SRRD_FLAGS_SHIFT     6'h21
`endif

// [verilog/srrd_pkg.sv]
// types for the shift, rotate, return and borrow-subtract decode timing block
package srrd_pkg;
  typedef enum logic [3:0] {
    SRRD_OP_NONE  = 4'h0,
    SRRD_OP_RET   = 4'h1,
    SRRD_OP_ROL   = 4'h2,
    SRRD_OP_ROR   = 4'h3,
    SRRD_OP_SAL   = 4'h4,
    SRRD_OP_SAR   = 4'h5,
    SRRD_OP_FLAGS = 4'h6,
    SRRD_OP_SBB   = 4'h7
  } srrd_op_e;
  typedef enum logic [1:0] {
    SRRD_IDLE = 2'b00,
    SRRD_BUSY = 2'b01,
    SRRD_DONE = 2'b11
  } srrd_state_e;
endpackage : srrd_pkg

// [bench/srrd_decode_tb_top.sv]
// self-checking testbench for the return, shift, flag load and borrow subtract decoder
`timescale 1ns/100ps
module srrd_decode_tb_top;
  // ****************
  // signals
  // ****************
  logic               mclk = 1'b0;
  logic               reset = 1'b1;
  logic               start = 1'b0;
  logic [7:0]         opcode = 8'h00;
  logic [7:0]         modrm = 8'h00;
  logic               prot_mode = 1'b0;
  logic               priv_change = 1'b0;
  logic               cache_miss = 1'b0;
  logic               busy, done, illegal;
  srrd_pkg::srrd_op_e op;
  logic               rol_o, ror_o, sal_o, sar_o, ret_o, flg_o, sbb_o;
  logic               use_count_reg_low, add_imm_stack_pointer, full_width, mem_operand;
  logic [5:0]         flag_mask;
  logic [6:0]         clocks;
  int                 n_errors = 0;
  int                 n_tests = 0;

  always #25 mclk = ~mclk;

  srrd_decode srrd_decode_inst (
    .mclk(mclk), .reset(reset), .start(start), .opcode(opcode), .modrm(modrm),
    .prot_mode(prot_mode), .priv_change(priv_change), .cache_miss(cache_miss),
    .busy(busy), .done(done), .illegal(illegal), .op(op),
    .rotate_left_op(rol_o), .rotate_right_op(ror_o), .arith_shift_left_op(sal_o),
    .arith_shift_right_op(sar_o), .subroutine_return_op(ret_o),
    .flags_from_acc_high_op(flg_o), .subtract_with_borrow_op(sbb_o),
    .use_count_reg_low(use_count_reg_low), .add_imm_stack_pointer(add_imm_stack_pointer),
    .full_width(full_width), .mem_operand(mem_operand), .flag_mask(flag_mask),
    .clocks(clocks)
  );

  // ****************
  // shared tasks
  // ****************
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict

  // one instruction: n is the expected clock count, done must come n cycles after accept
  task automatic run(input logic [7:0] opc, input logic [7:0] mrm, input logic pm,
                     input logic pv, input logic cm, input int n, input srrd_pkg::srrd_op_e eo);
    int k;
    @(posedge mclk);
    start <= 1'b1;
    opcode <= opc;
    modrm <= mrm;
    prot_mode <= pm;
    priv_change <= pv;
    cache_miss <= cm;
    @(posedge mclk);
    start <= 1'b0;
    k = 0;
    do begin
      @(negedge mclk);
      k++;
      if (k == 1) begin
        chk("clocks", 8'(n), {1'b0, clocks});
        chk("op", 8'(eo), 8'(op));
        if (n > 1) chk("busy", 8'h01, {7'h00, busy});
      end
    end while (done !== 1'b1 && k < 100);
    chk("done_cycle", 8'(n), 8'(k));
  endtask : run

  // ****************
  // scenarios
  // ****************
  task automatic t_return;
    run(8'hc3, 8'h00, 1'b0, 1'b0, 1'b0, 10, srrd_pkg::SRRD_OP_RET);
    chk("ret_line", 8'h01, {7'h00, ret_o});
    chk("imm_sp", 8'h00, {7'h00, add_imm_stack_pointer});
    run(8'hc3, 8'h00, 1'b1, 1'b0, 1'b1, 10, srrd_pkg::SRRD_OP_RET);
    run(8'hc2, 8'h00, 1'b0, 1'b0, 1'b1, 10, srrd_pkg::SRRD_OP_RET);
    run(8'hc2, 8'h00, 1'b1, 1'b0, 1'b0, 10, srrd_pkg::SRRD_OP_RET);
    chk("imm_sp", 8'h01, {7'h00, add_imm_stack_pointer});
    run(8'hca, 8'h00, 1'b0, 1'b0, 1'b0, 13, srrd_pkg::SRRD_OP_RET);
    run(8'hca, 8'h00, 1'b0, 1'b0, 1'b1, 13, srrd_pkg::SRRD_OP_RET);
    run(8'hca, 8'h00, 1'b1, 1'b1, 1'b0, 61, srrd_pkg::SRRD_OP_RET);
    run(8'hcb, 8'h00, 1'b1, 1'b1, 1'b1, 64, srrd_pkg::SRRD_OP_RET);
    run(8'hcb, 8'h00, 1'b1, 1'b0, 1'b0, 26, srrd_pkg::SRRD_OP_RET);
    run(8'hca, 8'h00, 1'b1, 1'b0, 1'b1, 27, srrd_pkg::SRRD_OP_RET);
    $display("test returns done");
  endtask : t_return

  // all four decoded selects, every count form, register, hit and miss; w alternates with the select
  task automatic t_shift;
    logic [2:0] sel [4] = '{3'h0, 3'h1, 3'h4, 3'h7};
    srrd_pkg::srrd_op_e eo [4] = '{srrd_pkg::SRRD_OP_ROL, srrd_pkg::SRRD_OP_ROR,
                                   srrd_pkg::SRRD_OP_SAL, srrd_pkg::SRRD_OP_SAR};
    logic [7:0] base [3] = '{8'hd0, 8'hc0, 8'hd2};
    logic [7:0] opc;
    logic [7:0] mrm;
    for (int s = 0; s < 4; s++) begin
      for (int f = 0; f < 3; f++) begin
        for (int m = 0; m < 3; m++) begin
          opc = base[f] | 8'(s & 1);
          mrm = {(m == 0) ? 2'h3 : 2'h0, sel[s], 3'h1};
          run(opc, mrm, m[0], 1'b0, m == 2, ((f == 2) ? 3 : 2) + 2 * m, eo[s]);
          chk("shift_lines", 8'h08 >> s, {4'h0, rol_o, ror_o, sal_o, sar_o});
          chk("count_form", 8'(f == 2), {7'h00, use_count_reg_low});
          chk("full_width", {7'h00, opc[0]}, {7'h00, full_width});
          chk("mem_operand", 8'(m != 0), {7'h00, mem_operand});
        end
      end
    end
    $display("test shifts done");
  endtask : t_shift

  task automatic t_flags;
    run(8'h9e, 8'h00, 1'b0, 1'b0, 1'b0, 2, srrd_pkg::SRRD_OP_FLAGS);
    chk("flags_line", 8'h01, {7'h00, flg_o});
    chk("flag_mask", 8'h1f, {2'h0, flag_mask});
    $display("test flag load done");
  endtask : t_flags

  // register, hit and miss for the two-operand and the immediate group forms
  task automatic t_sbb;
    int n;
    for (int i = 0; i < 8; i++) begin
      for (int m = 0; m < 3; m++) begin
        n = (m == 0) ? 1 : 1 + 2 * m;
        run((i < 4) ? 8'(8'h18 + i) : 8'(8'h7c + i), {(m == 0) ? 2'h3 : 2'h0, 3'h3, 3'h2},
            1'b0, 1'b0, m == 2, n, srrd_pkg::SRRD_OP_SBB);
        chk("sbb_line", 8'h01, {7'h00, sbb_o});
        chk("flag_mask", 8'h3f, {2'h0, flag_mask});
      end
    end
    run(8'h1c, 8'h00, 1'b0, 1'b0, 1'b1, 1, srrd_pkg::SRRD_OP_SBB);
    run(8'h1d, 8'h00, 1'b1, 1'b0, 1'b0, 1, srrd_pkg::SRRD_OP_SBB);
    chk("flag_mask", 8'h3f, {2'h0, flag_mask});
    $display("test borrow subtract done");
  endtask : t_sbb

  // an undecoded shift select gives a one-cycle illegal pulse and no count
  task automatic t_illegal;
    @(posedge mclk);
    start <= 1'b1;
    opcode <= 8'hd0;
    modrm <= 8'hd1;
    @(posedge mclk);
    start <= 1'b0;
    @(negedge mclk);
    chk("illegal", 8'h01, {7'h00, illegal});
    chk("busy", 8'h00, {7'h00, busy});
    @(negedge mclk);
    chk("illegal", 8'h00, {7'h00, illegal});
    $display("test illegal select done");
  endtask : t_illegal

  // a start while counting must not disturb the count already running
  // outputs are read on the falling edge so the launching edge never races the check
  task automatic t_refuse;
    int k;
    @(posedge mclk);
    start <= 1'b1;
    opcode <= 8'hc3;
    @(posedge mclk);
    start <= 1'b0;
    @(negedge mclk);
    k = 1;
    while (done !== 1'b1 && k < 100) begin
      @(posedge mclk);
      start <= (k == 3);
      opcode <= (k >= 3) ? 8'h9e : 8'hc3;
      @(negedge mclk);
      k++;
    end
    chk("done_cycle", 8'd10, 8'(k));
    chk("op", 8'(srrd_pkg::SRRD_OP_RET), 8'(op));
    $display("test ignored start done");
  endtask : t_refuse

  // ****************
  // main sequence
  // ****************
  initial begin
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    t_return();
    t_shift();
    t_flags();
    t_sbb();
    t_illegal();
    t_refuse();
    print_verdict();
  end

  // the whole run is under two thousand cycles; this span is ten times that
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    print_verdict();
  end
endmodule : srrd_decode_tb_top
